// ===== power_down_pkg.sv
// power_down_pkg: constants shared by the power-down mode controller
// assumes an APB master with 32-bit data and a 250 MHz pclk
package power_down_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h04;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // system_control field layout
    localparam int BIT_STANDBY_SELECT = 7;
    localparam int BIT_SETTLE_HI = 6;
    localparam int BIT_SETTLE_LO = 4;
    localparam int BIT_EXT_RESET_FLAG = 3;
    localparam logic [7:0] SYSCTL_RESET = 8'h09;
    localparam logic [7:0] SYSCTL_RO_MASK = 8'h08;

    // mode_status field layout
    localparam int BIT_SETTLING = 3;

    // ----------------------------------------
    // settle codes and counts
    // ----------------------------------------
    localparam int SETTLE_W = 18;
    localparam logic [2:0] SETTLE_CODE_SHORT = 3'h5;
    localparam int unsigned SETTLE_8K = 8192;
    localparam int unsigned SETTLE_16K = 16384;
    localparam int unsigned SETTLE_32K = 32768;
    localparam int unsigned SETTLE_64K = 65536;
    localparam int unsigned SETTLE_128K = 131072;
    localparam int unsigned SETTLE_1K = 1024;

    // ----------------------------------------
    // modes
    // ----------------------------------------
    typedef enum {
        ST_RUN, ST_SLEEP, ST_SW_STANDBY, ST_SETTLE, ST_HW_STANDBY, ST_RESET_HOLD
    } mode_state_type;

    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_SW_STANDBY = 3'h2;
    localparam logic [2:0] MODE_HW_STANDBY = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h4;
endpackage

// ===== power_down_mode_control.sv
// power_down_mode_control: sleep / software standby / hardware standby sequencer
// assumes sleep_req is a one-cycle pulse from the CPU and all pins are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none

module power_down_mode_control #(
    parameter int unsigned SETTLE_CNT_8K = power_down_pkg::SETTLE_8K,
    parameter int unsigned SETTLE_CNT_16K = power_down_pkg::SETTLE_16K,
    parameter int unsigned SETTLE_CNT_32K = power_down_pkg::SETTLE_32K,
    parameter int unsigned SETTLE_CNT_64K = power_down_pkg::SETTLE_64K,
    parameter int unsigned SETTLE_CNT_128K = power_down_pkg::SETTLE_128K,
    parameter int unsigned SETTLE_CNT_1K = power_down_pkg::SETTLE_1K,
    parameter bit FLASH_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [power_down_pkg::ADDR_W-1:0] paddr,
    input wire logic [power_down_pkg::DATA_W-1:0] pwdata,
    output logic [power_down_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu and interrupt sources
    input wire logic sleep_req,
    input wire logic any_int_req,
    input wire logic nmi_req,
    input wire logic [7:0] irq_req,
    input wire logic [7:0] irq_enable,
    input wire logic key_wake_input,
    // external pins
    input wire logic reset_input_n,
    input wire logic hw_standby_pin_n,
    // power controls
    output logic cpu_halt,
    output logic sys_clk_stop,
    output logic osc_run,
    output logic module_reset,
    output logic io_float,
    output logic int_start,
    output logic [2:0] mode_code
);
    import power_down_pkg::*;

    // ----------------------------------------
    // settle count lookup
    // ----------------------------------------
    // unused codes 100 and 11x fall on the longest count so a bad setting never shortens settling
    function automatic logic [SETTLE_W-1:0] settle_limit(input logic [2:0] code);
        logic [SETTLE_W-1:0] lim;
        lim = SETTLE_W'(SETTLE_CNT_128K);
        case (code)
            3'h0: lim = SETTLE_W'(SETTLE_CNT_8K);
            3'h1: lim = SETTLE_W'(SETTLE_CNT_16K);
            3'h2: lim = SETTLE_W'(SETTLE_CNT_32K);
            3'h3: lim = SETTLE_W'(SETTLE_CNT_64K);
            SETTLE_CODE_SHORT: begin
                if (FLASH_VARIANT) begin
                    lim = SETTLE_W'(SETTLE_CNT_1K);
                end
            end
            default: lim = SETTLE_W'(SETTLE_CNT_128K);
        endcase
        return lim;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    mode_state_type state_ff;
    mode_state_type nxt_state;
    logic [7:0] sysctl_ff;
    logic [7:0] nxt_sysctl;
    logic [SETTLE_W-1:0] cnt_ff;
    logic [SETTLE_W-1:0] nxt_cnt;
    logic int_start_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic [DATA_W-1:0] nxt_prdata;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic setup_phase = psel & ~penable;
    wire logic access_phase = psel & penable;
    wire logic hit_sysctl = (paddr == ADDR_SYSTEM_CONTROL);
    wire logic hit_status = (paddr == ADDR_MODE_STATUS);
    wire logic mapped = hit_sysctl | hit_status;
    wire logic wr_sysctl = access_phase & pwrite & hit_sysctl;
    wire logic standby_select = sysctl_ff[BIT_STANDBY_SELECT];
    wire logic [2:0] settle_time_sel = sysctl_ff[BIT_SETTLE_HI:BIT_SETTLE_LO];
    // only nmi, irq0..2 and irq6 (key inputs ride on irq6) can restart the oscillator
    wire logic irq6_wake = (irq_req[6] | key_wake_input) & irq_enable[6];
    wire logic standby_wake = nmi_req | |(irq_req[2:0] & irq_enable[2:0]) | irq6_wake;
    wire logic sleep_wake = any_int_req | nmi_req;
    wire logic settle_done = (cnt_ff == settle_limit(settle_time_sel) - SETTLE_W'(1));
    wire logic in_standby_like = (state_ff == ST_SW_STANDBY) || (state_ff == ST_SETTLE);

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    // standby pin first, then reset pin: both override whatever mode is active
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        if (!hw_standby_pin_n) begin
            nxt_state = ST_HW_STANDBY;
        end else if (!reset_input_n) begin
            nxt_state = ST_RESET_HOLD;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (sleep_req) begin
                        nxt_state = standby_select ? ST_SW_STANDBY : ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (sleep_wake) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_SW_STANDBY: begin
                    if (standby_wake) begin
                        nxt_state = ST_SETTLE;
                        nxt_cnt = '0;
                    end
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_cnt = cnt_ff + SETTLE_W'(1);
                    end
                end
                ST_HW_STANDBY: begin
                    // pin released while reset is still low goes to reset hold above;
                    // released with reset high also ends in reset, never straight to run
                    nxt_state = ST_RESET_HOLD;
                end
                ST_RESET_HOLD: begin
                    nxt_state = ST_RUN;
                end
                default: nxt_state = ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // system control register
    // ----------------------------------------
    // hardware standby and reset hold reinitialise it; standby_select is untouched by a wake
    always_comb begin
        nxt_sysctl = sysctl_ff;
        if ((state_ff == ST_HW_STANDBY) || (state_ff == ST_RESET_HOLD)) begin
            nxt_sysctl = SYSCTL_RESET;
        end else if (wr_sysctl) begin
            nxt_sysctl = (pwdata[7:0] & ~SYSCTL_RO_MASK) | (sysctl_ff & SYSCTL_RO_MASK);
        end
    end

    // read data captured in setup so prdata leaves a flip-flop
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup_phase && !pwrite) begin
            nxt_prdata = '0;
            if (hit_sysctl) begin
                nxt_prdata[7:0] = sysctl_ff;
            end else if (hit_status) begin
                nxt_prdata[2:0] = mode_code;
                nxt_prdata[BIT_SETTLING] = (state_ff == ST_SETTLE);
            end
        end
    end

    // ----------------------------------------
    // flip-flops
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_RUN;
            sysctl_ff <= SYSCTL_RESET;
            cnt_ff <= '0;
            int_start_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            sysctl_ff <= nxt_sysctl;
            cnt_ff <= nxt_cnt;
            int_start_ff <= (state_ff == ST_SETTLE) && (nxt_state == ST_RUN);
            prdata_ff <= nxt_prdata;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;
    assign prdata = prdata_ff;
    assign int_start = int_start_ff;

    // sleep halts only the CPU; standby also stops the clock and resets modules
    assign cpu_halt = (state_ff != ST_RUN);
    assign sys_clk_stop = in_standby_like || (state_ff == ST_HW_STANDBY);
    assign osc_run = (state_ff != ST_SW_STANDBY) && (state_ff != ST_HW_STANDBY);
    assign module_reset = in_standby_like || (state_ff == ST_HW_STANDBY)
        || (state_ff == ST_RESET_HOLD);
    assign io_float = (state_ff == ST_HW_STANDBY);

    always_comb begin
        case (state_ff)
            ST_SLEEP: mode_code = MODE_SLEEP;
            ST_SW_STANDBY: mode_code = MODE_SW_STANDBY;
            ST_SETTLE: mode_code = MODE_SW_STANDBY;
            ST_HW_STANDBY: mode_code = MODE_HW_STANDBY;
            ST_RESET_HOLD: mode_code = MODE_RESET;
            default: mode_code = MODE_RUN;
        endcase
    end
endmodule // power_down_mode_control

`default_nettype wire

// ===== power_down_asserts.sv
// power_down_asserts: port checker for the power-down mode controller
// assumes it is bound onto every power_down_mode_control instance
`timescale 1ns/100ps
`default_nettype none
module power_down_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [power_down_pkg::ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // cpu, pins and power controls
    input wire logic sleep_req,
    input wire logic reset_input_n,
    input wire logic hw_standby_pin_n,
    input wire logic cpu_halt,
    input wire logic sys_clk_stop,
    input wire logic osc_run,
    input wire logic module_reset,
    input wire logic io_float,
    input wire logic int_start,
    input wire logic [2:0] mode_code
);
    import power_down_pkg::*;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire pins_hi = reset_input_n && hw_standby_pin_n;
    // oscillator restart while the mode still reads standby
    sequence s_osc_wake;
        mode_code == MODE_SW_STANDBY && !osc_run ##1 osc_run && mode_code == MODE_SW_STANDBY;
    endsequence
    a_sleep_halts: assert property (mode_code == MODE_RUN && sleep_req && pins_hi |=> cpu_halt)
        else $error("cpu not halted after sleep request");
    a_sleep_runs: assert property (mode_code == MODE_SLEEP |->
        cpu_halt && !sys_clk_stop && osc_run && !module_reset) else $error("sleep outputs wrong");
    a_soft_stop: assert property (mode_code == MODE_SW_STANDBY |->
        sys_clk_stop && module_reset && cpu_halt) else $error("standby outputs wrong");
    a_settle_hold: assert property (s_osc_wake |-> cpu_halt && sys_clk_stop)
        else $error("chip released at oscillator start");
    a_hw_enter: assert property (!hw_standby_pin_n |=> mode_code == MODE_HW_STANDBY && io_float)
        else $error("hardware standby not entered");
    a_reset_pin: assert property (hw_standby_pin_n && !reset_input_n |=> mode_code == MODE_RESET)
        else $error("reset pin ignored");
    a_int_once: assert property (int_start |-> mode_code == MODE_RUN ##1 !int_start)
        else $error("interrupt start pulse wrong");
    a_float_hw: assert property (io_float |-> mode_code == MODE_HW_STANDBY)
        else $error("ports float outside hardware standby");
    a_apb_err: assert property (psel && penable && paddr != ADDR_SYSTEM_CONTROL &&
        paddr != ADDR_MODE_STATUS |-> pready && pslverr) else $error("unmapped access not refused");
endmodule // power_down_asserts
bind power_down_mode_control power_down_asserts chk_i (.*);
`default_nettype wire

// ===== power_down_cpu_model.sv
// power_down_cpu_model: cpu core and interrupt sources facing the controller
// assumes the bench calls its tasks; requests change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module power_down_cpu_model (
    // clock
    input wire logic pclk,
    // requests toward the controller
    output logic sleep_req,
    output logic any_int_req,
    output logic nmi_req,
    output logic [7:0] irq_req,
    output logic key_wake_input
);
    initial begin
        sleep_req = 1'b0;
        any_int_req = 1'b0;
        nmi_req = 1'b0;
        irq_req = 8'h00;
        key_wake_input = 1'b0;
    end
    // sleep instruction: a single-cycle request
    task automatic sleep_now();
        @(posedge pclk);
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
    endtask
    // 0 nmi, 1..3 irq0..2, 4 key, 5 irq3 (no standby wake), 6 plain interrupt, 7 all released
    task automatic raise(input int src);
        @(posedge pclk);
        nmi_req <= (src == 0);
        irq_req <= (src >= 1 && src <= 3) ? 8'h01 << (src - 1) : ((src == 5) ? 8'h08 : 8'h00);
        key_wake_input <= (src == 4);
        any_int_req <= (src != 0) && (src != 7);
    endtask
endmodule // power_down_cpu_model
`default_nettype wire

// ===== power_down_mode_control_tb_top.sv
// power_down_mode_control_tb_top: self-checking bench for the mode controller
// assumes shortened settle counts; drives at rising edges, samples at falling
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_control_tb_top;
    import power_down_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, any_int_req, nmi_req;
    logic key_wake_input, reset_input_n, hw_standby_pin_n, cpu_halt, sys_clk_stop, osc_run;
    logic module_reset, io_float, int_start, err;
    logic [7:0] paddr, irq_req, irq_enable;
    logic [31:0] pwdata, prdata, r, d;
    logic [2:0] mode_code;
    int mismatches, compares, n;
    // shortened settle counts keep the run well inside the cycle budget
    localparam int unsigned CNT_8K = 16;
    localparam int unsigned CNT_16K = 32;
    localparam int unsigned CNT_32K = 64;
    localparam int unsigned CNT_64K = 128;
    localparam int unsigned CNT_128K = 256;
    localparam int unsigned CNT_1K = 8;
    power_down_mode_control #(.SETTLE_CNT_8K(CNT_8K), .SETTLE_CNT_16K(CNT_16K),
        .SETTLE_CNT_32K(CNT_32K), .SETTLE_CNT_64K(CNT_64K), .SETTLE_CNT_128K(CNT_128K),
        .SETTLE_CNT_1K(CNT_1K)) dut (.*);
    power_down_cpu_model cpu (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic int exp_settle(input logic [2:0] c);
        case (c)
            3'h0: return CNT_8K;
            3'h1: return CNT_16K;
            3'h2: return CNT_32K;
            3'h3: return CNT_64K;
            3'h5: return CNT_1K;
            default: return CNT_128K;
        endcase
    endfunction
    task automatic end_sim();
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        {r, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic wait_mode(input logic [2:0] m);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (mode_code !== m && n < 400);
        if (mode_code !== m) begin
            mismatches++;
            end_sim();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {reset_input_n, hw_standby_pin_n, irq_enable} = {2'b11, 8'h47};
        n = $urandom(32'h315bafb6);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_SYSTEM_CONTROL, 32'h0);
        chk(r, {24'h0, SYSCTL_RESET});
        repeat (4) begin
            d = $urandom;
            apb(1'b1, ADDR_SYSTEM_CONTROL, d);
            apb(1'b0, ADDR_SYSTEM_CONTROL, 32'h0);
            chk(r, (d & 32'hF7) | 32'h08);
        end
        apb(1'b0, 8'h08, 32'h0);
        chk(err, 1'b1);
        chk(r, 32'h0);
        apb(1'b1, ADDR_SYSTEM_CONTROL, 32'h01);
        cpu.sleep_now();
        @(negedge pclk);
        chk({mode_code, cpu_halt, sys_clk_stop, osc_run}, {MODE_SLEEP, 3'b101});
        chk(module_reset, 1'b0);
        apb(1'b0, ADDR_MODE_STATUS, 32'h0);
        chk(r, {29'h0, MODE_SLEEP});
        cpu.raise(6);
        wait_mode(MODE_RUN);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ADDR_SYSTEM_CONTROL, {24'h0, 1'b1, 3'(c), 4'h1});
            // random enables, but the wake sources under test always stay enabled
            irq_enable <= 8'($urandom) | 8'h47;
            cpu.sleep_now();
            cpu.raise(5);
            repeat (3) @(negedge pclk);
            chk({mode_code, osc_run}, {MODE_SW_STANDBY, 1'b0});
            chk({sys_clk_stop, module_reset}, 2'b11);
            cpu.raise(c % 5);
            wait_mode(MODE_RUN);
            // n also covers the edge that sees the wake and the first run cycle
            chk(n, exp_settle(3'(c)) + 2);
            chk(int_start, 1'b1);
            cpu.raise(7);
            apb(1'b0, ADDR_SYSTEM_CONTROL, 32'h0);
            chk(r, {24'h0, 1'b1, 3'(c), 4'h9});
        end
        apb(1'b1, ADDR_SYSTEM_CONTROL, 32'h01);
        cpu.sleep_now();
        @(posedge pclk);
        hw_standby_pin_n <= 1'b0;
        repeat (2) @(negedge pclk);
        chk({mode_code, io_float}, {MODE_HW_STANDBY, 1'b1});
        apb(1'b1, ADDR_SYSTEM_CONTROL, 32'hF1);
        {reset_input_n, hw_standby_pin_n} <= 2'b01;
        repeat (2) @(negedge pclk);
        chk(mode_code, MODE_RESET);
        @(posedge pclk);
        reset_input_n <= 1'b1;
        wait_mode(MODE_RUN);
        apb(1'b0, ADDR_SYSTEM_CONTROL, 32'h0);
        chk(r, {24'h0, SYSCTL_RESET});
        cpu.sleep_now();
        @(posedge pclk);
        reset_input_n <= 1'b0;
        repeat (2) @(negedge pclk);
        chk(mode_code, MODE_RESET);
        @(posedge pclk);
        reset_input_n <= 1'b1;
        wait_mode(MODE_RUN);
        end_sim();
    end
endmodule // power_down_mode_control_tb_top
`default_nettype wire
